// ===== fcm_pkg.sv
// Shared constants, types and coding tables for the forced-config and media-select block
`default_nettype none
package fcm_pkg;

  // ------------------------------------------------------------
  // Register map and fields
  // ------------------------------------------------------------
  localparam logic [7:0] REG_WINDOW = 8'h00;
  localparam logic [7:0] REG_INT_CFG = 8'h04;
  localparam logic [7:0] REG_NET_DIAG = 8'h08;
  localparam logic [7:0] REG_PCI_CMD = 8'h0C;
  localparam logic [7:0] REG_IO_BASE = 8'h10;
  localparam logic [7:0] REG_ROM_CTL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;
  localparam logic [2:0] WIN_CFG = 3'h3;
  localparam int XCVR_LSB = 20;
  localparam logic [3:0] XCVR_10 = 4'h0;
  localparam logic [3:0] XCVR_100 = 4'h4;
  localparam logic [3:0] XCVR_MII = 4'h6;
  localparam logic [3:0] XCVR_AUTO = 4'h8;
  localparam int DIAG_MDC = 0;
  localparam int DIAG_MDO = 1;
  localparam int DIAG_MOE = 2;
  localparam int DIAG_MDI = 3;
  localparam int CMD_IO = 0;
  localparam int CMD_MEM = 1;
  localparam int CMD_MST = 2;
  localparam int ROM_EN = 0;

  // ------------------------------------------------------------
  // Reset values and fixed settings
  // ------------------------------------------------------------
  localparam logic [2:0] WINDOW_RST = 3'h0;
  localparam logic [31:0] INT_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] IO_BASE_RST = 16'h0000;
  localparam logic [15:0] FORCED_IO_BASE = 16'h0200;
  localparam int IO_WIN_BITS = 5;
  localparam logic [10:0] LFSR_SEED = 11'h7ff;

  // ------------------------------------------------------------
  // Line timing: periods in mclk cycles, silence limits in half-bits and bits (scaled line rates)
  // ------------------------------------------------------------
  localparam int HALF10_CYC = 8;
  localparam int BIT100_CYC = 4;
  localparam int SIL10_HALVES = 3;
  localparam int SIL100_BITS = 24;

  typedef enum logic [1:0] {PATH_10 = 2'b00, PATH_100 = 2'b01, PATH_MII = 2'b10} fcm_path_t;
  typedef enum logic [1:0] {T100_IDLE = 2'b00, T100_START = 2'b01, T100_DATA = 2'b10} fcm_tx100_t;

  // Nibble to five-bit code group
  function automatic logic [4:0] fcm_enc5(input logic [3:0] n);
    logic [4:0] c;
    c = 5'h1e;
    unique case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      4'hf: c = 5'h1d;
    endcase
    return c;
  endfunction : fcm_enc5

  // Five-bit code group back to nibble; unknown groups give zero
  function automatic logic [3:0] fcm_dec5(input logic [4:0] c);
    logic [3:0] n;
    n = 4'h0;
    for (int i = 0; i < 16; i++) begin
      if (fcm_enc5(4'(i)) == c) begin
        n = 4'(i);
      end
    end
    return n;
  endfunction : fcm_dec5

endpackage : fcm_pkg
`default_nettype wire

// ===== fcm_media_select.sv
// Forced PCI configuration, media path selection and line coding for the Ethernet MAC
//
// Behaviour
// - Forced mode answers PCI accesses with no configuration cycles or EEPROM load.
// - Forced mode decodes the I/O block at fixed base 200h.
// - Forced mode claims I/O cycles and refuses memory cycles.
// - Forced mode enables bus mastering and disables expansion ROM cycles.
// - Three media paths: 10 Mbps, 100BASE-TX and external MII.
// - Exactly one path at a time connects to the MAC.
// - Path choice comes from transceiver select plus auto-negotiation result.
// - 10 Mbps path does Manchester coding and receive clock recovery.
// - 100 Mbps path does 4B/5B, scrambling, transmit clock and clock recovery.
// - PHY registers over the management interface steer auto-negotiation.
// - MII carries separate 4-bit paths, routed only while the MII path is the active path.
// - Management link is driven and sampled through network diagnostic bits.
// - The internal config register is reached in I/O window 3.
`default_nettype none
module fcm_media_select #(
  parameter int HALF10 = fcm_pkg::HALF10_CYC,
  parameter int BIT100 = fcm_pkg::BIT100_CYC
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic forcedCfgPin,
  input wire logic [15:0] tgtAddr,
  input wire logic tgtIoReq,
  input wire logic tgtMemReq,
  input wire logic tgtRomReq,
  output logic ioClaim,
  output logic memClaim,
  output logic romClaim,
  output logic busMasterEn,
  input wire logic anDone,
  input wire logic anSpeed100,
  input wire logic [3:0] macTxd,
  input wire logic macTxEn,
  output logic macTxStb,
  output logic [3:0] macRxd,
  output logic macRxDv,
  output logic macRxStb,
  output logic tp10Tx,
  input wire logic tp10Rx,
  output logic tx100Line,
  input wire logic rx100Line,
  input wire logic miiTxClk,
  output logic [3:0] miiTxd,
  output logic miiTxEn,
  input wire logic miiRxClk,
  input wire logic [3:0] miiRxd,
  input wire logic miiRxDv,
  output logic mdc,
  output logic mdioOut,
  output logic mdioOe,
  input wire logic mdioIn
);
  import fcm_pkg::*;

  localparam int PW10 = $clog2(HALF10 + 1);
  localparam int PW100 = $clog2(BIT100 + 1);
  localparam int SIL10 = SIL10_HALVES * HALF10;
  localparam int SIL100 = SIL100_BITS * BIT100;
  localparam int SW10 = $clog2(SIL10 + 1);
  localparam int SW100 = $clog2(SIL100 + 1);

  // ------------------------------------------------------------
  // Pin synchronisers (first stage read only by second)
  // ------------------------------------------------------------
  logic [1:0] strapS, rx10S, rx100S, mTxcS, mRxcS, mdiS;
  logic [9:0] mRxS1, mRxS2;
  logic rx10Prev, rx100Prev, mTxcPrev, mRxcPrev;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {strapS, rx10S, rx100S, mTxcS, mRxcS, mdiS} <= '0;
      {mRxS1, mRxS2} <= '0;
      {rx10Prev, rx100Prev, mTxcPrev, mRxcPrev} <= '0;
    end else begin
      strapS <= {strapS[0], forcedCfgPin};
      rx10S <= {rx10S[0], tp10Rx};
      rx100S <= {rx100S[0], rx100Line};
      mTxcS <= {mTxcS[0], miiTxClk};
      mRxcS <= {mRxcS[0], miiRxClk};
      mdiS <= {mdiS[0], mdioIn};
      mRxS1 <= {5'h00, miiRxDv, miiRxd};
      mRxS2 <= mRxS1;
      {rx10Prev, rx100Prev, mTxcPrev, mRxcPrev} <= {rx10S[1], rx100S[1], mTxcS[1], mRxcS[1]};
    end
  end

  // ------------------------------------------------------------
  // AHB-Lite register slave, zero wait states
  // ------------------------------------------------------------
  logic [2:0] windowReg;
  logic [31:0] intCfgReg, rdataReg;
  logic [2:0] diagReg;
  logic [2:0] pciCmdReg;
  logic [15:0] ioBaseReg;
  logic romCtlReg, wrPend, forcedReg, forcedDone;
  logic [1:0] strapCnt;
  logic [7:0] wrAddr;
  fcm_path_t activePath;
  logic tx10Busy, rxIdle, txIdle;
  fcm_tx100_t tx100State;

  // Address phase decode and read mux
  wire addrTake = hsel & hready & htrans[1];
  wire inMap = (haddr[31:8] == 24'h00_0000);
  wire [7:0] ra = haddr[7:0];
  wire cfgOpen = (windowReg == WIN_CFG);
  wire [31:0] rdMux =
      !inMap ? 32'h0000_0000 :
      (ra == REG_WINDOW) ? 32'(windowReg) :
      (ra == REG_INT_CFG) ? (cfgOpen ? intCfgReg : 32'h0000_0000) :
      (ra == REG_NET_DIAG) ? 32'({mdiS[1], diagReg[2:0]}) :
      (ra == REG_PCI_CMD) ? 32'(pciCmdReg) :
      (ra == REG_IO_BASE) ? 32'(ioBaseReg) :
      (ra == REG_ROM_CTL) ? 32'(romCtlReg) :
      (ra == REG_STATUS) ? 32'({!rxIdle, !txIdle, anSpeed100, anDone, forcedReg, activePath}) :
      32'h0000_0000;
  wire wrWin = wrPend && (wrAddr == REG_WINDOW);
  wire wrCfg = wrPend && (wrAddr == REG_INT_CFG) && cfgOpen;
  wire wrDiag = wrPend && (wrAddr == REG_NET_DIAG);
  wire wrCmd = wrPend && (wrAddr == REG_PCI_CMD);
  wire wrBase = wrPend && (wrAddr == REG_IO_BASE);
  wire wrRom = wrPend && (wrAddr == REG_ROM_CTL);
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdataReg;

  // Capture transfer and return read data
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      rdataReg <= 32'h0000_0000;
    end else begin
      wrPend <= addrTake & hwrite & inMap;
      if (addrTake) begin
        wrAddr <= ra;
      end
      if (addrTake & !hwrite) begin
        rdataReg <= rdMux;
      end
    end
  end

  // Writable registers, applied in the data phase
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      windowReg <= WINDOW_RST;
      intCfgReg <= INT_CFG_RST;
      diagReg <= 3'h0;
      pciCmdReg <= 3'h0;
      ioBaseReg <= IO_BASE_RST;
      romCtlReg <= 1'b0;
    end else begin
      if (wrWin) windowReg <= hwdata[2:0];
      if (wrCfg) intCfgReg <= hwdata;
      if (wrDiag) diagReg <= {hwdata[DIAG_MOE], hwdata[DIAG_MDO], hwdata[DIAG_MDC]};
      if (wrCmd) pciCmdReg <= hwdata[2:0];
      if (wrBase) ioBaseReg <= hwdata[15:0];
      if (wrRom) romCtlReg <= hwdata[ROM_EN];
    end
  end

  // ------------------------------------------------------------
  // Forced configuration
  // ------------------------------------------------------------
  // Strap taken after release
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      strapCnt <= 2'd0;
      forcedDone <= 1'b0;
      forcedReg <= 1'b0;
    end else if (!forcedDone) begin
      strapCnt <= strapCnt + 2'd1;
      if (strapCnt == 2'd2) begin
        forcedReg <= strapS[1];
        forcedDone <= 1'b1;
      end
    end
  end

  wire ioEn = forcedReg | pciCmdReg[CMD_IO];
  wire memEn = !forcedReg & pciCmdReg[CMD_MEM];
  wire romEn = !forcedReg & romCtlReg;
  wire [15:0] ioBase = forcedReg ? FORCED_IO_BASE : ioBaseReg;
  wire ioHit = (tgtAddr[15:IO_WIN_BITS] == ioBase[15:IO_WIN_BITS]);
  assign ioClaim = tgtIoReq & ioEn & ioHit;
  assign memClaim = tgtMemReq & memEn;
  assign busMasterEn = forcedReg | pciCmdReg[CMD_MST];
  assign romClaim = tgtRomReq & romEn;

  // ------------------------------------------------------------
  // Media selection
  // ------------------------------------------------------------
  wire [3:0] xcvr = intCfgReg[XCVR_LSB +: 4];
  wire fcm_path_t wantPath =
      (xcvr == XCVR_10) ? PATH_10 :
      (xcvr == XCVR_100) ? PATH_100 :
      (xcvr == XCVR_MII) ? PATH_MII :
      (xcvr == XCVR_AUTO && anDone) ? (anSpeed100 ? PATH_100 : PATH_10) :
      activePath;
  assign txIdle = !macTxEn && !tx10Busy && (tx100State == T100_IDLE) && !miiTxEn;
  assign rxIdle = !macRxDv;
  wire sel10 = (activePath == PATH_10);
  wire sel100 = (activePath == PATH_100);
  wire selMii = (activePath == PATH_MII);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      activePath <= PATH_10;
    end else if (txIdle && rxIdle) begin
      activePath <= wantPath;
    end
  end

  // ------------------------------------------------------------
  // Line rate dividers (transmit clock generation)
  // ------------------------------------------------------------
  logic [PW10-1:0] div10;
  logic [PW100-1:0] div100;
  wire tick10 = (div10 == PW10'(HALF10 - 1));
  wire tick100 = (div100 == PW100'(BIT100 - 1));
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      div10 <= '0;
      div100 <= '0;
    end else begin
      div10 <= tick10 ? '0 : div10 + PW10'(1);
      div100 <= tick100 ? '0 : div100 + PW100'(1);
    end
  end

  // ------------------------------------------------------------
  // 10 Mbps transmit: Manchester, first half inverted
  // ------------------------------------------------------------
  logic [3:0] tx10Nib;
  logic [1:0] tx10Bit;
  logic tx10Half;
  wire tx10Last = tx10Busy && tx10Half && (tx10Bit == 2'd3);
  wire stb10 = tick10 && sel10 && macTxEn && (!tx10Busy || tx10Last);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {tx10Busy, tx10Half, tx10Bit, tx10Nib, tp10Tx} <= '0;
    end else if (tick10) begin
      if (stb10) begin
        {tx10Busy, tx10Half, tx10Bit, tx10Nib} <= {2'b10, 2'd0, macTxd};
        tp10Tx <= !macTxd[0];
      end else if (tx10Last || !tx10Busy) begin
        {tx10Busy, tp10Tx} <= 2'b00;
      end else begin
        tx10Half <= !tx10Half;
        tx10Bit <= tx10Half ? tx10Bit + 2'd1 : tx10Bit;
        tp10Tx <= tx10Half ? !tx10Nib[tx10Bit + 2'd1] : tx10Nib[tx10Bit];
      end
    end
  end

  // ------------------------------------------------------------
  // 100 Mbps transmit: start bit, then scrambled code groups
  // ------------------------------------------------------------
  logic [4:0] tx100Sym;
  logic [2:0] tx100Idx;
  logic [10:0] txLfsr;
  // Last code bit leaves in this tick, so the next group follows with no gap
  wire tx100End = (tx100State == T100_DATA) && (tx100Idx == 3'd3);
  wire stb100 = tick100 && sel100 && macTxEn && ((tx100State == T100_IDLE) || tx100End);
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      tx100State <= T100_IDLE;
      {tx100Sym, tx100Idx, tx100Line} <= '0;
      txLfsr <= LFSR_SEED;
    end else if (tick100) begin
      unique case (tx100State)
        T100_IDLE: begin
          tx100Line <= stb100;
          txLfsr <= LFSR_SEED;
          if (stb100) begin
            tx100State <= T100_START;
            tx100Sym <= fcm_enc5(macTxd);
          end
        end
        T100_START, T100_DATA: begin
          tx100Line <= tx100Sym[4] ^ txLfsr[0];
          txLfsr <= {txLfsr[0] ^ txLfsr[2], txLfsr[10:1]};
          tx100Sym <= {tx100Sym[3:0], 1'b0};
          tx100Idx <= (tx100State == T100_START) ? 3'd0 : tx100Idx + 3'd1;
          tx100State <= T100_DATA;
        end
        default: tx100State <= T100_IDLE;
      endcase
      if (tx100End) begin
        tx100Idx <= 3'd0;
        tx100State <= stb100 ? T100_START : T100_IDLE;
        if (stb100) tx100Sym <= fcm_enc5(macTxd);
      end
    end
  end

  // ------------------------------------------------------------
  // MII transmit, data moved on the PHY's transmit clock edge
  // ------------------------------------------------------------
  wire mTxRise = mTxcS[1] & !mTxcPrev;
  wire stbMii = mTxRise && selMii && macTxEn;
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      miiTxd <= 4'h0;
      miiTxEn <= 1'b0;
    end else if (mTxRise) begin
      miiTxd <= selMii ? macTxd : 4'h0;
      miiTxEn <= selMii & macTxEn;
    end
  end
  assign macTxStb = stb10 | stb100 | stbMii;

  // ------------------------------------------------------------
  // 10 Mbps receive: edge-aligned phase, half-bit pairing
  // ------------------------------------------------------------
  logic [PW10-1:0] ph10;
  logic [SW10-1:0] sil10;
  logic rx10Have, rx10First, rx10Stb;
  logic [1:0] rx10Cnt;
  logic [3:0] rx10Nib, rx10Out;
  wire edge10 = rx10S[1] ^ rx10Prev;
  wire act10 = (sil10 < SW10'(SIL10));
  wire samp10 = act10 && (ph10 == PW10'(HALF10 / 2));
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {ph10, sil10, rx10Have, rx10First, rx10Stb, rx10Cnt, rx10Nib, rx10Out} <= '0;
      sil10 <= SW10'(SIL10);
    end else begin
      ph10 <= (edge10 || ph10 == PW10'(HALF10 - 1)) ? '0 : ph10 + PW10'(1);
      sil10 <= edge10 ? '0 : (act10 ? sil10 + SW10'(1) : sil10);
      rx10Stb <= 1'b0;
      if (!act10) begin
        {rx10Have, rx10Cnt} <= '0;
      end else if (samp10) begin
        if (!rx10Have || rx10First == rx10S[1]) begin
          {rx10Have, rx10First} <= {1'b1, rx10S[1]};
        end else begin
          rx10Have <= 1'b0;
          rx10Nib[rx10Cnt] <= rx10S[1];
          rx10Cnt <= rx10Cnt + 2'd1;
          if (rx10Cnt == 2'd3) begin
            rx10Out <= {rx10S[1], rx10Nib[2:0]};
            rx10Stb <= 1'b1;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------
  // 100 Mbps receive: start bit hunt, descramble, 5B/4B decode
  // ------------------------------------------------------------
  logic [PW100-1:0] ph100;
  logic [SW100-1:0] sil100;
  logic rx100Run, rx100Stb;
  logic [2:0] rx100Cnt;
  logic [3:0] rx100Sh, rx100Out;
  logic [10:0] rxLfsr;
  wire edge100 = rx100S[1] ^ rx100Prev;
  wire act100 = (sil100 < SW100'(SIL100));
  wire samp100 = act100 && (ph100 == PW100'(BIT100 / 2));
  wire rx100Bit = rx100S[1] ^ rxLfsr[0];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {ph100, rx100Run, rx100Stb, rx100Cnt, rx100Sh, rx100Out} <= '0;
      sil100 <= SW100'(SIL100);
      rxLfsr <= LFSR_SEED;
    end else begin
      ph100 <= (edge100 || ph100 == PW100'(BIT100 - 1)) ? '0 : ph100 + PW100'(1);
      sil100 <= edge100 ? '0 : (act100 ? sil100 + SW100'(1) : sil100);
      rx100Stb <= 1'b0;
      if (!act100) begin
        rx100Run <= 1'b0;
      end else if (samp100 && !rx100Run) begin
        {rx100Run, rx100Cnt} <= {rx100S[1], 3'd0};
        rxLfsr <= LFSR_SEED;
      end else if (samp100) begin
        rx100Sh <= {rx100Sh[2:0], rx100Bit};
        rxLfsr <= {rxLfsr[0] ^ rxLfsr[2], rxLfsr[10:1]};
        rx100Cnt <= (rx100Cnt == 3'd4) ? 3'd0 : rx100Cnt + 3'd1;
        if (rx100Cnt == 3'd4) begin
          rx100Out <= fcm_dec5({rx100Sh, rx100Bit});
          rx100Stb <= 1'b1;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Receive mux to the MAC and management pins
  // ------------------------------------------------------------
  wire mRxRise = mRxcS[1] & !mRxcPrev;
  wire [3:0] rxdSel = sel10 ? rx10Out : (sel100 ? rx100Out : mRxS2[3:0]);
  wire rxDvSel = sel10 ? act10 : (sel100 ? rx100Run : mRxS2[4]);
  wire rxStbSel = sel10 ? rx10Stb : (sel100 ? rx100Stb : (mRxRise & mRxS2[4]));
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      {macRxd, macRxDv, macRxStb} <= '0;
    end else begin
      macRxd <= rxStbSel ? rxdSel : macRxd;
      macRxDv <= rxDvSel;
      macRxStb <= rxStbSel;
    end
  end
  assign mdc = diagReg[DIAG_MDC];
  assign mdioOut = diagReg[DIAG_MDO];
  assign mdioOe = diagReg[DIAG_MOE];

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  sequence diagWrite;
    addrTake && hwrite && inMap && ra == REG_NET_DIAG ##1 1'b1;
  endsequence
  sequence cfgBlocked;
    addrTake && hwrite && ra == REG_INT_CFG && !cfgOpen ##1 windowReg != WIN_CFG;
  endsequence
  forced_io_a: assert property (forcedReg && tgtIoReq && tgtAddr[15:5] == 11'h010 |-> ioClaim)
    else $error("forced mode missed I/O at fixed base");
  forced_mem_a: assert property (forcedReg && tgtMemReq |-> !memClaim)
    else $error("forced mode claimed a memory cycle");
  forced_rom_a: assert property (forcedReg |-> busMasterEn && !romClaim)
    else $error("forced mode master or ROM setting wrong");
  path_idle_a: assert property (!$stable(activePath) |-> $past(txIdle && rxIdle))
    else $error("media path changed during traffic");
  mii_route_a: assert property ($rose(miiTxEn) |-> activePath == PATH_MII && xcvr == XCVR_MII)
    else $error("MII driven without MII selection");
  auto_pick_a: assert property (xcvr == XCVR_AUTO && anDone && anSpeed100 && txIdle && rxIdle
      |=> activePath == PATH_100)
    else $error("auto path did not follow negotiation");
  diag_pins_a: assert property (diagWrite |=> mdc == $past(hwdata[DIAG_MDC]))
    else $error("management clock does not follow register");
  cfg_window_a: assert property (cfgBlocked |=> $stable(intCfgReg))
    else $error("config written outside window 3");
  strap_hold_a: assert property (forcedDone |=> $stable(forcedReg))
    else $error("forced mode changed before reset");

endmodule : fcm_media_select
`default_nettype wire

// ===== fcm_phy_model.sv
// Behavioural external PHY on the MII data and management lines
`default_nettype none
module fcm_phy_model (
  input wire logic go,
  input wire logic mdioOut,
  input wire logic mdioOe,
  output logic mdioIn,
  output logic miiTxClk,
  output logic miiRxClk,
  output logic [3:0] miiRxd,
  output logic miiRxDv
);
  timeunit 1ns;
  timeprecision 1ns;
  // Free running PHY clocks, slower than mclk/4 and out of phase
  initial begin
    miiTxClk = 0;
    miiRxClk = 0;
    miiRxd = 0;
    miiRxDv = 0;
  end
  always #370 miiTxClk = ~miiTxClk;
  always #400 miiRxClk = ~miiRxClk;
  assign mdioIn = mdioOe ? mdioOut : 1'b1;
  always @(posedge go) begin
    for (int i = 0; i < 4; i++) begin
      @(negedge miiRxClk);
      miiRxDv = 1;
      miiRxd = 4'(3 * i + 5);
    end
    @(negedge miiRxClk);
    miiRxDv = 0;
    miiRxd = ~miiRxd; // Stale data must not look valid
  end
endmodule : fcm_phy_model
`default_nettype wire

// ===== test_forced_config_media_select.sv
// Self-checking bench for forced configuration and media selection
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
`define WAIT(c) for (n = 0; n < 999 && !(c); n++) @(posedge mclk); \
  if (n == 999) begin err_total++; end_of_test; end
module test_forced_config_media_select;
  timeunit 1ns;
  timeprecision 1ns;
  import fcm_pkg::*;
  logic mclk = 0, sys_rst = 1, hsel = 0, hwrite = 0, forcedCfgPin = 1, go = 0;
  logic tgtIoReq = 0, tgtMemReq = 0, tgtRomReq = 0, anDone = 0, anSpeed100 = 0, macTxEn = 0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, q;
  logic [1:0] htrans = '0;
  logic [15:0] tgtAddr = '0;
  logic [3:0] macTxd = '0, macRxd, miiTxd, miiRxd;
  logic hreadyout, hresp, ioClaim, memClaim, romClaim, busMasterEn, macTxStb, macRxDv;
  logic macRxStb, tp10Tx, tx100Line, miiTxClk, miiRxClk, miiTxEn, miiRxDv;
  logic mdc, mdioOut, mdioOe, mdioIn;
  int err_total = 0, n_tests = 0, n;
  always #50 mclk = ~mclk;
  // Line outputs looped back into their own receivers
  fcm_media_select dut_u (.mclk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .forcedCfgPin, .tgtAddr,
    .tgtIoReq, .tgtMemReq, .tgtRomReq, .ioClaim, .memClaim, .romClaim, .busMasterEn,
    .anDone, .anSpeed100, .macTxd, .macTxEn, .macTxStb, .macRxd, .macRxDv, .macRxStb,
    .tp10Tx, .tp10Rx(tp10Tx), .tx100Line, .rx100Line(tx100Line), .miiTxClk, .miiTxd, .miiTxEn,
    .miiRxClk, .miiRxd, .miiRxDv, .mdc, .mdioOut, .mdioOe, .mdioIn);
  fcm_phy_model phy_u (.go, .mdioOut, .mdioOe, .mdioIn, .miiTxClk, .miiRxClk, .miiRxd,
    .miiRxDv);
  // ----------------------------------------
  // Bus and pin tasks
  // ----------------------------------------
  task automatic end_of_test;
    $display("errors %0d checks %0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : end_of_test
  task automatic rst(input logic p);
    sys_rst <= 1;
    forcedCfgPin <= p;
    repeat (12) @(posedge mclk);
    sys_rst <= 0;
    repeat (4) @(posedge mclk);
  endtask : rst
  // One AHB single transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge mclk);
    `WAIT(hreadyout === 1'b1)
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge mclk);
    `WAIT(hreadyout === 1'b1)
    q = hrdata;
  endtask : bus
  // PCI target request; expect {master, rom, mem, io}
  task automatic tg(input logic [2:0] r, input logic [15:0] a, input logic [3:0] e);
    {tgtRomReq, tgtMemReq, tgtIoReq} <= r;
    tgtAddr <= a;
    @(negedge mclk);
    `CHK({busMasterEn, romClaim, memClaim, ioClaim}, e)
    @(posedge mclk);
    {tgtRomReq, tgtMemReq, tgtIoReq} <= 3'b0;
    @(posedge mclk);
  endtask : tg
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_forced;
    tg(3'b001, 16'h0200, 4'h9);
    tg(3'b001, 16'h021f, 4'h9);
    tg(3'b001, 16'h0220, 4'h8);
    bus(1, REG_PCI_CMD, 32'h2);
    bus(1, REG_ROM_CTL, 32'h1);
    tg(3'b010, 16'h0200, 4'h8);
    tg(3'b100, 16'h0200, 4'h8);
    bus(0, REG_STATUS, 0);
    `CHK(q[2], 1'b1)
  endtask : t_forced
  task automatic t_prog;
    rst(0);
    tg(3'b001, 16'h0200, 4'h0);
    bus(1, REG_IO_BASE, 32'h300);
    bus(1, REG_PCI_CMD, 32'h7);
    tg(3'b001, 16'h0300, 4'h9);
    tg(3'b010, 16'h0300, 4'ha);
  endtask : t_prog
  task automatic t_window;
    bus(1, REG_INT_CFG, 32'h0060_0000);
    bus(0, REG_INT_CFG, 0);
    `CHK(q, 32'h0)
    bus(1, REG_WINDOW, 32'h3);
    bus(1, REG_INT_CFG, 32'h0060_0000);
    bus(0, REG_INT_CFG, 0);
    `CHK(q, 32'h0060_0000)
  endtask : t_window
  task automatic t_path;
    logic [3:0] cd[5] = '{XCVR_100, XCVR_MII, XCVR_10, XCVR_AUTO, XCVR_AUTO};
    logic [1:0] ep[5] = '{2'h1, 2'h2, 2'h0, 2'h1, 2'h0};
    anDone <= 1;
    foreach (cd[i]) begin
      anSpeed100 <= (i == 3);
      bus(1, REG_INT_CFG, {8'h0, cd[i], 20'h0});
      repeat (3) @(posedge mclk);
      bus(0, REG_STATUS, 0);
      `CHK(q[1:0], ep[i])
    end
  endtask : t_path
  task automatic t_mii;
    bus(1, REG_INT_CFG, 32'h0060_0000);
    repeat (3) @(posedge mclk);
    go <= 1;
    for (int i = 0; i < 4; i++) begin
      `WAIT(macRxStb === 1'b1)
      `CHK({macRxDv, macRxd}, {1'b1, 4'(3 * i + 5)})
      @(posedge mclk);
    end
    macTxd <= 4'h9;
    macTxEn <= 1;
    `WAIT(miiTxEn === 1'b1)
    `CHK(miiTxd, 4'h9)
    macTxEn <= 0;
  endtask : t_mii
  task automatic t_mdio;
    bus(1, REG_NET_DIAG, 32'h4);
    repeat (4) @(posedge mclk);
    `CHK({mdioOe, mdioOut, mdc}, 3'h4)
    bus(0, REG_NET_DIAG, 0);
    `CHK(q, 32'h4)
    bus(1, REG_NET_DIAG, 32'h3);
    repeat (4) @(posedge mclk);
    bus(0, REG_NET_DIAG, 0);
    `CHK(q, 32'hb)
  endtask : t_mdio
  // One nibble sent on each coded line and decoded back through the loop
  task automatic t_line;
    bus(1, REG_INT_CFG, {8'h0, XCVR_10, 20'h0});
    repeat (3) @(posedge mclk);
    macTxd <= 4'h6;
    macTxEn <= 1;
    `WAIT(macTxStb === 1'b1)
    macTxEn <= 0;
    `WAIT(macRxStb === 1'b1)
    `CHK(macRxd, 4'h6)
    bus(1, REG_INT_CFG, {8'h0, XCVR_100, 20'h0});
    repeat (40) @(posedge mclk);
    bus(0, REG_STATUS, 0);
    `CHK(q[1:0], 2'h1)
    macTxd <= 4'h3;
    macTxEn <= 1;
    `WAIT(macTxStb === 1'b1)
    macTxEn <= 0;
    `WAIT(macRxStb === 1'b1)
    `CHK(macRxd, 4'h3)
  endtask : t_line
  // Main sequence and hang guard
  initial begin
    rst(1);
    t_forced;
    t_prog;
    t_window;
    t_path;
    t_mii;
    t_mdio;
    t_line;
    end_of_test;
  end
  initial begin
    #2_000_000;
    err_total++;
    end_of_test;
  end
endmodule : test_forced_config_media_select
`default_nettype wire
